// >>> design/las_pkg.sv
// Package for the line acquisition sequencer: modes, widths, timing constants.
// Assumes a 100 MHz system clock shared by all design files.
package las_pkg;

  localparam int PIX_W = 12;
  localparam int LINE_LEN_W = 13;
  localparam int FIFO_DEPTH = 4;
  localparam int BUF_DEPTH = 4096;
  localparam int BUF_AW = 12;

  // Clock and trigger rates
  localparam int CLK_HZ = 100_000_000;
  localparam int SINGLE_MAX_HZ = 70_000;
  localparam int DUAL_MAX_HZ = 140_000;
  localparam int SINGLE_MIN_PERIOD = CLK_HZ / SINGLE_MAX_HZ;
  localparam int DUAL_MIN_PERIOD = CLK_HZ / DUAL_MAX_HZ;

  // Reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [LINE_LEN_W-1:0] LEN_RESET = 13'h0_800;

  typedef enum logic [3:0] {
    LAS_SINGLE,
    LAS_DUAL_A_FIRST,
    LAS_DUAL_B_FIRST,
    LAS_VBIN,
    LAS_TDS_A_DELAYED,
    LAS_TDS_B_DELAYED,
    LAS_AVERAGE,
    LAS_TDA_A_DELAYED,
    LAS_TDA_B_DELAYED
  } las_mode_e;

  typedef struct packed {
    logic [PIX_W-1:0] line_a;
    logic [PIX_W-1:0] line_b;
    logic last;
  } las_pix_s;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic last;
  } las_out_s;

endpackage

// >>> design/las_fifo.sv
// Small valid/ready FIFO for outgoing pixels.
// Assumes single clock, asynchronous active-high reset.
`timescale 1ns/10ps
module las_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// >>> design/las_line_buffer.sv
// One-line store for the deferred line of a dual line pair.
// Assumes single clock; read data is registered, one cycle latency.
`timescale 1ns/10ps
module las_line_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// >>> design/las_sequencer.sv
// Line acquisition sequencer: trigger handling, exposure, readout and output.
// Assumes inputs synchronous to clk; sensor pixels come as A/B pairs.
`timescale 1ns/10ps
// Summary of operation
// (R1) Nine acquisition modes selectable by mode code.
// (R2) Single mode exposes and sends line A only.
// (R3) Single mode supports triggers up to 70 kHz.
// (R4) A-first: expose both, send A, buffer B.
// (R5) A-first: next trigger sends buffered B.
// (R6) B-first: send B now, buffered A next.
// (R7) Dual modes support triggers up to 140 kHz.
// (R8) Dual modes only on 140 kHz variants.
// (R9) Source gives two triggers per dual pair.
// (R10) First dual trigger: one exposure, both lines.
// (R11) First trigger starts readout and first transmission.
// (R12) Second trigger only starts buffered transmission.
// (R13) Host picks order by object travel direction.
// (R14) Mode field write selects operating mode.
// (R15) Horizontal binning combines with any mode.
// (R16) Trigger is edge sensitive, rising edge.
// (R17) One buffered line; mode change discards it.
// (R18) Line and data valid only with pixels.
module las_sequencer #(
  parameter bit DUAL_CAPABLE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic external_line_trigger,
  input wire logic [3:0] mode_field,
  input wire logic horiz_binning,
  input wire logic [las_pkg::LINE_LEN_W-1:0] line_length,
  input wire logic [15:0] exposure_cycles,
  output logic sensor_expose_a,
  output logic sensor_expose_b,
  output logic sensor_read_req,
  input wire las_pkg::las_pix_s sensor_pix,
  input wire logic sensor_pix_valid,
  output logic [las_pkg::PIX_W-1:0] pixel_data,
  output logic line_valid,
  output logic data_valid,
  input wire logic link_ready,
  output logic [3:0] active_mode,
  output logic buffer_pending,
  output logic trigger_overrun
);
  import las_pkg::*;

  // ----------------------------------------------------------------
  // State and signals
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LAS_IDLE,
    LAS_EXPOSE,
    LAS_READOUT,
    LAS_REPLAY
  } las_state_e;

  las_state_e state;
  logic trig_prev;
  logic trig_edge;
  logic [15:0] exp_cnt;
  logic [BUF_AW-1:0] pix_idx;
  logic [BUF_AW-1:0] rd_idx;
  logic [BUF_AW-1:0] last_idx;
  logic [PIX_W-1:0] raw_pix;
  logic replay_rd;
  logic replay_vld;
  logic replay_last;
  logic [3:0] mode_applied;
  logic is_dual;
  logic rate_busy;
  logic [15:0] period_cnt;
  logic [15:0] min_period;
  logic [PIX_W-1:0] first_pix;
  logic [PIX_W-1:0] second_pix;
  logic [PIX_W-1:0] bin_hold;
  logic bin_phase;
  logic [PIX_W:0] pair_sum;
  logic [PIX_W-1:0] stream_pix;
  logic stream_last;
  logic stream_valid;
  las_out_s fifo_in;
  las_out_s fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic buf_rd_valid_d;
  logic [PIX_W-1:0] buf_rd_data;
  logic readout_active;
  logic mode_legal;

  assign trig_edge = external_line_trigger && !trig_prev; // [R16]
  // Dual codes refused on parts without the fast readout
  assign mode_legal = (mode_field <= 4'h8) &&
    (DUAL_CAPABLE || (mode_field != 4'h1 && mode_field != 4'h2)); // [R8]
  assign is_dual = (mode_applied == 4'h1) || (mode_applied == 4'h2);
  assign readout_active = (state == LAS_READOUT);
  assign min_period = is_dual ? 16'(DUAL_MIN_PERIOD) : 16'(SINGLE_MIN_PERIOD); // [R3] [R7]

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_applied <= MODE_RESET;
    end else if (state == LAS_IDLE && mode_legal) begin
      mode_applied <= mode_field; // [R1] [R14]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= external_line_trigger;
    end
  end

  // ----------------------------------------------------------------
  // Trigger rate supervision
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period_cnt <= '1;
      trigger_overrun <= 1'b0;
    end else begin
      if (trig_edge) begin
        period_cnt <= '0;
      end else if (period_cnt != 16'hFFFF) begin
        period_cnt <= period_cnt + 16'h0001;
      end
      trigger_overrun <= trig_edge && rate_busy;
    end
  end

  assign rate_busy = (state != LAS_IDLE) || (period_cnt < min_period);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= LAS_IDLE;
      exp_cnt <= '0;
      buffer_pending <= 1'b0;
    end else begin
      case (state)
        LAS_IDLE: begin
          if (mode_legal && mode_field != mode_applied) begin
            buffer_pending <= 1'b0; // [R17]
          end else if (trig_edge && is_dual && buffer_pending) begin
            state <= LAS_REPLAY; // [R5] [R12]
          end else if (trig_edge) begin
            exp_cnt <= exposure_cycles;
            state <= LAS_EXPOSE; // [R10]
          end
        end
        LAS_EXPOSE: begin
          if (exp_cnt <= 16'h0001) begin
            state <= LAS_READOUT; // [R11]
          end else begin
            exp_cnt <= exp_cnt - 16'h0001;
          end
        end
        LAS_READOUT: begin
          if (sensor_pix_valid && fifo_in_ready && sensor_pix.last) begin
            buffer_pending <= is_dual; // [R4] [R6]
            state <= LAS_IDLE;
          end
        end
        LAS_REPLAY: begin
          if (replay_last && replay_vld && fifo_in_ready) begin
            buffer_pending <= 1'b0;
            state <= LAS_IDLE;
          end
        end
        default: state <= LAS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sensor control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sensor_expose_a <= 1'b0;
      sensor_expose_b <= 1'b0;
      sensor_read_req <= 1'b0;
    end else begin
      sensor_expose_a <= (state == LAS_EXPOSE); // [R2]
      sensor_expose_b <= (state == LAS_EXPOSE) && (mode_applied != 4'h0); // [R10]
      sensor_read_req <= readout_active && fifo_in_ready && !sensor_read_req; // Room known
    end
  end

  // ----------------------------------------------------------------
  // Pixel combination
  // ----------------------------------------------------------------
  always_comb begin
    first_pix = (mode_applied == 4'h2) ? sensor_pix.line_b : sensor_pix.line_a; // [R6]
    second_pix = (mode_applied == 4'h2) ? sensor_pix.line_a : sensor_pix.line_b;
    pair_sum = {1'b0, sensor_pix.line_a} + {1'b0, sensor_pix.line_b};
    case (mode_applied)
      4'h3, 4'h4, 4'h5: stream_pix = pair_sum[PIX_W] ? '1 : pair_sum[PIX_W-1:0];
      4'h6, 4'h7, 4'h8: stream_pix = PIX_W'((pair_sum + 1'b1) >> 1);
      default: stream_pix = first_pix;
    endcase
  end

  // Line index during readout, also the buffer write address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_idx <= '0;
      last_idx <= '0;
    end else if (readout_active && sensor_pix_valid && fifo_in_ready) begin
      pix_idx <= sensor_pix.last ? '0 : pix_idx + 1'b1;
      if (sensor_pix.last) begin
        last_idx <= pix_idx;
      end
    end
  end

  las_line_buffer #(
    .WIDTH(PIX_W),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_line_buffer (
    .clk(clk),
    .wr_en(readout_active && sensor_pix_valid && fifo_in_ready && is_dual), // [R4]
    .wr_addr(pix_idx),
    .wr_data(second_pix),
    .rd_addr(rd_idx),
    .rd_data(buf_rd_data)
  );

  // ----------------------------------------------------------------
  // Replay of the buffered line
  // ----------------------------------------------------------------
  assign replay_rd = (state == LAS_REPLAY) && !replay_last && (!replay_vld || fifo_in_ready);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_idx <= '0;
      replay_vld <= 1'b0;
      replay_last <= 1'b0;
      buf_rd_valid_d <= 1'b0;
    end else if (state != LAS_REPLAY) begin
      rd_idx <= '0;
      replay_vld <= 1'b0;
      replay_last <= 1'b0;
      buf_rd_valid_d <= 1'b0;
    end else begin
      if (replay_vld && fifo_in_ready) begin
        replay_vld <= 1'b0;
        if (rd_idx != last_idx) begin
          rd_idx <= rd_idx + 1'b1;
        end
      end
      if (replay_rd && !buf_rd_valid_d) begin
        buf_rd_valid_d <= 1'b1;
      end else if (buf_rd_valid_d) begin
        buf_rd_valid_d <= 1'b0;
        replay_vld <= 1'b1;
        replay_last <= (rd_idx == last_idx);
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stream, with optional horizontal binning
  // ----------------------------------------------------------------
  always_comb begin
    if (state == LAS_REPLAY) begin
      stream_valid = replay_vld;
      stream_last = replay_last;
      raw_pix = buf_rd_data;
    end else begin
      stream_valid = readout_active && sensor_pix_valid;
      stream_last = sensor_pix.last;
      raw_pix = stream_pix;
    end
    fifo_in.last = stream_last;
    fifo_in.data = raw_pix;
    if (horiz_binning) begin
      fifo_in.data = PIX_W'(({1'b0, bin_hold} + {1'b0, raw_pix}) >> 1); // [R15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bin_phase <= 1'b0;
      bin_hold <= '0;
    end else if (stream_valid && fifo_in_ready) begin
      bin_phase <= stream_last ? 1'b0 : !bin_phase;
      bin_hold <= raw_pix;
    end
  end

  las_fifo #(
    .WIDTH($bits(las_out_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(fifo_in),
    .in_valid(stream_valid && (!horiz_binning || bin_phase || stream_last)),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(link_ready)
  );

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pixel_data <= '0;
      data_valid <= 1'b0;
      line_valid <= 1'b0;
      active_mode <= MODE_RESET;
    end else begin
      active_mode <= mode_applied;
      data_valid <= fifo_out_valid && link_ready; // [R18]
      pixel_data <= (fifo_out_valid && link_ready) ? fifo_out.data : '0;
      if (fifo_out_valid && link_ready) begin
        line_valid <= 1'b1;
      end else if (line_valid && data_valid && fifo_out.last == 1'b0) begin
        line_valid <= line_valid;
      end
      if (data_valid && !(fifo_out_valid && link_ready)) begin
        line_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  valid_qual_a: assert property (@(posedge clk) disable iff (rst)
    data_valid |-> line_valid) else $error("data valid outside line"); // [R18]
  edge_start_a: assert property (@(posedge clk) disable iff (rst)
    (state == LAS_IDLE && $rose(external_line_trigger) && !is_dual && mode_legal
     && mode_field == mode_applied) |=> state == LAS_EXPOSE)
    else $error("trigger edge did not start exposure"); // [R16]
  dual_replay_a: assert property (@(posedge clk) disable iff (rst)
    (state == LAS_IDLE && trig_edge && is_dual && buffer_pending
     && mode_field == mode_applied) |=> state == LAS_REPLAY)
    else $error("second trigger did not replay"); // [R5]
  no_expose_a: assert property (@(posedge clk) disable iff (rst)
    state == LAS_REPLAY |=> !sensor_expose_a) else $error("replay exposed"); // [R12]
  single_line_a: assert property (@(posedge clk) disable iff (rst)
    mode_applied == 4'h0 |-> !sensor_expose_b) else $error("line B in single"); // [R2]
  both_lines_a: assert property (@(posedge clk) disable iff (rst)
    (state == LAS_EXPOSE && is_dual) |=> sensor_expose_a && sensor_expose_b)
    else $error("dual exposure not on both lines"); // [R10]
  pend_set_a: assert property (@(posedge clk) disable iff (rst)
    (readout_active && sensor_pix_valid && fifo_in_ready && sensor_pix.last && is_dual)
    |=> buffer_pending) else $error("buffered line not pending"); // [R4]
  discard_a: assert property (@(posedge clk) disable iff (rst)
    (state == LAS_IDLE && mode_legal && mode_field != mode_applied) |=> !buffer_pending)
    else $error("mode change kept buffer"); // [R17]
  variant_a: assert property (@(posedge clk) disable iff (rst)
    !DUAL_CAPABLE |-> !is_dual) else $error("dual mode on slow variant"); // [R8]

  cov_single_c: cover property (@(posedge clk) state == LAS_EXPOSE && mode_applied == 4'h0);
  cov_replay_c: cover property (@(posedge clk) state == LAS_REPLAY);
  cov_bfirst_c: cover property (@(posedge clk) state == LAS_READOUT && mode_applied == 4'h2);
  cov_overrun_c: cover property (@(posedge clk) trigger_overrun);
endmodule

// >>> test/las_sensor_model.sv
// Far-side model: sensor beats on read request, link sink with stalls.
// Assumes the sequencer registers sensor_read_req and takes a beat while it is high.
`timescale 1ns/10ps
module las_sensor_model #(
  parameter int LEN = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sensor_read_req,
  input wire logic stall_en,
  output las_pkg::las_pix_s sensor_pix,
  output logic sensor_pix_valid,
  output logic link_ready
);
  import las_pkg::*;
  logic [3:0] idx;
  logic [3:0] line_no;
  logic [1:0] ph;
  las_pix_s beat;
  // ----------------------------------------
  // Beat pattern: line tag, line number, pixel index
  // ----------------------------------------
  always_comb begin
    beat.line_a = {4'h1, line_no, idx};
    beat.line_b = {4'h2, line_no, idx};
    beat.last = (idx == 4'(LEN - 1));
  end
  // Bus shows inverted data when no beat is offered
  assign sensor_pix = sensor_read_req ? beat : ~beat;
  assign sensor_pix_valid = sensor_read_req;
  assign link_ready = !(stall_en && ph == 2'h3);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx <= 4'h0;
      line_no <= 4'h0;
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      if (sensor_read_req) begin
        if (idx == 4'(LEN - 1)) begin
          idx <= 4'h0;
          line_no <= line_no + 4'h1;
        end else begin
          idx <= idx + 4'h1;
        end
      end
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the line acquisition sequencer.
// Assumes las_sensor_model supplies sensor beats and link stalls.
`timescale 1ns/10ps
module testbench;
  import las_pkg::*;
  localparam int LEN = 6;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic trig = 1'b0;
  logic hbin = 1'b0;
  logic stall_en = 1'b0;
  logic [3:0] mode = 4'h0;
  logic exp_a, exp_b, read_req, pix_valid, link_ready;
  logic line_valid, data_valid, pending, overrun;
  logic [PIX_W-1:0] pixel_data;
  logic [3:0] active_mode;
  logic [3:0] slow_mode;
  las_pix_s pix;
  logic [PIX_W-1:0] q[$];
  int err_total = 0;
  int checks_done = 0;
  int n_a, n_b, n_ovr;
  logic [3:0] ln = 4'h0;
  always #5 clk = ~clk;
  las_sequencer dut (.clk(clk), .rst(rst), .external_line_trigger(trig),
    .mode_field(mode), .horiz_binning(hbin), .line_length(13'h0006),
    .exposure_cycles(16'h0014), .sensor_expose_a(exp_a), .sensor_expose_b(exp_b),
    .sensor_read_req(read_req), .sensor_pix(pix), .sensor_pix_valid(pix_valid),
    .pixel_data(pixel_data), .line_valid(line_valid), .data_valid(data_valid),
    .link_ready(link_ready), .active_mode(active_mode), .buffer_pending(pending),
    .trigger_overrun(overrun));
  las_sensor_model #(.LEN(LEN)) far (.clk(clk), .rst(rst), .sensor_read_req(read_req),
    .stall_en(stall_en), .sensor_pix(pix), .sensor_pix_valid(pix_valid),
    .link_ready(link_ready));
  // Variant without the fast readout, only its mode handling is judged
  las_sequencer #(.DUAL_CAPABLE(1'b0)) dut_slow (.clk(clk), .rst(rst),
    .external_line_trigger(trig), .mode_field(mode), .horiz_binning(hbin),
    .line_length(13'h0006), .exposure_cycles(16'h0014), .sensor_expose_a(),
    .sensor_expose_b(), .sensor_read_req(), .sensor_pix(pix), .sensor_pix_valid(pix_valid),
    .pixel_data(), .line_valid(), .data_valid(), .link_ready(link_ready),
    .active_mode(slow_mode), .buffer_pending(), .trigger_overrun());
  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (data_valid === 1'b1) q.push_back(pixel_data);
    if (exp_a === 1'b1) n_a++;
    if (exp_b === 1'b1) n_b++;
    if (overrun === 1'b1) n_ovr++;
    if (data_valid === 1'b1 && line_valid !== 1'b1) begin
      err_total++;
      $display("[FAIL] line_valid expected 1 seen %b", line_valid);
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] expv, input logic [15:0] got);
    checks_done++;
    if (got !== expv) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, expv, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Clean edge, held high a few cycles, then the trigger period runs out
  task automatic fire(input int gap);
    q.delete();
    n_a = 0;
    n_b = 0;
    n_ovr = 0;
    trig = 1'b1;
    repeat (3) @(negedge clk);
    trig = 1'b0;
    repeat (gap - 3) @(negedge clk);
  endtask
  task automatic expect_line(input string name, input logic [3:0] tag,
      input logic [3:0] lno, input int step);
    chk({name, " count"}, 16'(LEN / step), 16'(q.size()));
    for (int i = 0; i < q.size() && i < LEN / step; i++) begin
      chk(name, {4'h0, tag, lno, 4'(i * step)}, {4'h0, q[i]});
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_modes();
    for (int m = 0; m < 9; m++) begin
      mode = 4'(m);
      repeat (4) @(negedge clk);
      chk("active_mode", 16'(m), {12'h000, active_mode});
      chk("slow active_mode", (m == 1 || m == 2) ? 16'h0000 : 16'(m), {12'h000, slow_mode});
    end
    mode = 4'h9;
    repeat (4) @(negedge clk);
    chk("illegal mode ignored", 16'h0008, {12'h000, active_mode});
    mode = 4'h0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_single();
    fire(1500);
    expect_line("single pixels", 4'h1, ln, 1);
    chk("single expose_a", 16'h0014, 16'(n_a));
    chk("single expose_b", 16'h0000, 16'(n_b));
    ln++;
  endtask
  task automatic t_dual(input logic [3:0] m, input logic [3:0] first, input logic [3:0] second);
    mode = m;
    repeat (4) @(negedge clk);
    fire(800);
    expect_line("dual first", first, ln, 1);
    chk("dual expose_a", 16'h0014, 16'(n_a));
    chk("dual expose_b", 16'h0014, 16'(n_b));
    chk("dual pending", 16'h0001, {15'h0000, pending});
    chk("dual rate ok", 16'h0000, 16'(n_ovr));
    fire(800);
    expect_line("dual second", second, ln, 1);
    chk("replay no exposure", 16'h0000, 16'(n_a + n_b));
    chk("replay pending", 16'h0000, {15'h0000, pending});
    chk("replay rate ok", 16'h0000, 16'(n_ovr));
    ln++;
  endtask
  task automatic t_discard();
    mode = 4'h1;
    repeat (4) @(negedge clk);
    fire(1500);
    expect_line("before discard", 4'h1, ln, 1);
    mode = 4'h0;
    repeat (4) @(negedge clk);
    chk("discard pending", 16'h0000, {15'h0000, pending});
    ln++;
    fire(1500);
    expect_line("after discard", 4'h1, ln, 1);
    ln++;
  endtask
  task automatic t_overrun();
    fire(10);
    trig = 1'b1;
    repeat (3) @(negedge clk);
    trig = 1'b0;
    repeat (1500) @(negedge clk);
    chk("overrun pulses", 16'h0001, 16'(n_ovr));
    expect_line("overrun one line", 4'h1, ln, 1);
    ln++;
  endtask
  task automatic t_hbin();
    hbin = 1'b1;
    fire(1500);
    expect_line("binned pixels", 4'h1, ln, 2);
    hbin = 1'b0;
    ln++;
  endtask
  // Averaging: both lines, mean rounded up
  task automatic t_avg();
    mode = 4'h6;
    repeat (4) @(negedge clk);
    fire(1500);
    chk("avg count", 16'(LEN), 16'(q.size()));
    for (int i = 0; i < q.size() && i < LEN; i++) begin
      chk("avg pixels", 16'(12'h180 + {4'h0, ln, 4'h0} + 12'(i)), {4'h0, q[i]});
    end
    chk("avg expose_b", 16'h0014, 16'(n_b));
    ln++;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_modes();
    t_single();
    stall_en = 1'b1;
    t_single();
    t_dual(4'h1, 4'h1, 4'h2);
    t_dual(4'h2, 4'h2, 4'h1);
    t_discard();
    t_overrun();
    t_hbin();
    t_avg();
    final_report();
  end
endmodule
